// >>> verilog/fcgt_top.sv
/*
 * Equalizer filter configuration and fine-gain trim registers, with a
 * two-tap equalizer slice per channel (center and one side tap).
 * Assumes fuse contents are stable while FUSE_LOAD is pulsed, and that
 * coefficients come from the coefficient registers outside this block.
 */
//
// Overview of operation
// - Trims are 5-bit RW, reserved bits read zero
// - Separate dual-channel trims per bank, A and B
// - Independent single-channel trim set per bank
// - Trim defaults loaded from fuse storage
// - Share bit gives channel B channel A coefficients
// - Merge bit makes one interleaved filter
// - Side weight scales LSB to 2^(scw-16); the code scales the side product by 2^scw, with no bias
// - Mode 0 disables, mode 2 enables filter
// - Config bit 7 reserved RW, reset zero
// - Coefficients are signed 12-bit, first tap A
`timescale 1ns/100ps
`default_nettype none
module fcgt_top
    import fcgt_pkg::*;
#(
    parameter int SAMPLE_W = 8
)(
    input  wire logic                          REF_CLK,
    input  wire logic                          RST_N,
    input  wire logic                          REG_WR,
    input  wire logic                          REG_RD,
    input  wire logic [11:0]                   REG_ADDR,
    input  wire logic [7:0]                    REG_WDATA,
    output logic [7:0]                         REG_RDATA,
    input  wire logic                          FUSE_LOAD,
    input  wire logic [FCGT_NUM_TRIMS*5-1:0]   FUSE_TRIM,
    input  wire logic                          SINGLE_CHANNEL,
    input  wire logic signed [SAMPLE_W-1:0]    SAMPLE_A,
    input  wire logic signed [SAMPLE_W-1:0]    SAMPLE_B,
    input  wire logic signed [FCGT_COEF_W-1:0] COEF_A_CENTER,
    input  wire logic signed [FCGT_COEF_W-1:0] COEF_A_SIDE,
    input  wire logic signed [FCGT_COEF_W-1:0] COEF_B_CENTER,
    input  wire logic signed [FCGT_COEF_W-1:0] COEF_B_SIDE,
    output logic [FCGT_GAIN_W-1:0]             GAIN_A_BANK0,
    output logic [FCGT_GAIN_W-1:0]             GAIN_A_BANK1,
    output logic [FCGT_GAIN_W-1:0]             GAIN_B_BANK0,
    output logic [FCGT_GAIN_W-1:0]             GAIN_B_BANK1,
    output fcgt_cfg_t                          FILT_CFG,
    output logic signed [SAMPLE_W+FCGT_COEF_W+7:0] OUT_A,
    output logic signed [SAMPLE_W+FCGT_COEF_W+7:0] OUT_B
);

    localparam int PW = SAMPLE_W + FCGT_COEF_W + 7;

    // ************************************************************
    // Register file
    // ************************************************************
    logic [FCGT_GAIN_W-1:0] trim_r   [FCGT_NUM_TRIMS];
    logic [FCGT_GAIN_W-1:0] trim_nxt [FCGT_NUM_TRIMS];
    logic [7:0]             cfg_r;
    logic [7:0]             cfg_nxt;
    logic [7:0]             rdata_r;
    logic [7:0]             rdata_nxt;

    // Trim index from address, or -1 when not a trim register
    function automatic int trim_index(input logic [11:0] a);
        int idx;
        idx = -1;
        if (a >= FCGT_OFS_FG_A0_TWO && a <= FCGT_OFS_FG_B1_ONE)
        begin
            idx = int'(a - FCGT_OFS_FG_A0_TWO);
        end
        return idx;
    endfunction : trim_index

    // Next register values: fuse load, then software write; reads decode
    always_comb
    begin
        int wi;
        int ri;
        wi = trim_index(REG_ADDR);
        ri = trim_index(REG_ADDR);
        cfg_nxt   = cfg_r;
        rdata_nxt = rdata_r;
        for (int i = 0; i < FCGT_NUM_TRIMS; i++)
        begin
            trim_nxt[i] = trim_r[i];
            if (FUSE_LOAD)
            begin
                trim_nxt[i] = FUSE_TRIM[i*5 +: 5];
            end
            else if (REG_WR && wi == i)
            begin
                trim_nxt[i] = REG_WDATA[FCGT_GAIN_W-1:0];
            end
        end
        if (REG_WR && REG_ADDR == FCGT_OFS_FILT_CFG)
        begin
            cfg_nxt = REG_WDATA;
        end
        if (REG_RD)
        begin
            if (ri >= 0)
            begin
                rdata_nxt = {3'h0, trim_r[ri[2:0]]};
            end
            else if (REG_ADDR == FCGT_OFS_FILT_CFG)
            begin
                rdata_nxt = cfg_r;
            end
            else
            begin
                rdata_nxt = 8'h00;
            end
        end
    end

    // Register storage
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            for (int i = 0; i < FCGT_NUM_TRIMS; i++)
            begin
                trim_r[i] <= '0;
            end
            cfg_r   <= FCGT_CFG_RESET;
            rdata_r <= 8'h00;
        end
        else
        begin
            trim_r  <= trim_nxt;
            cfg_r   <= cfg_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign REG_RDATA = rdata_r;
    assign FILT_CFG  = fcgt_cfg_t'(cfg_r);

    // ************************************************************
    // Trim selection by channel mode
    // ************************************************************
    // Dual mode uses entries 0..3, single mode entries 4..7
    always_comb
    begin
        if (SINGLE_CHANNEL)
        begin
            GAIN_A_BANK0 = trim_r[4];
            GAIN_A_BANK1 = trim_r[5];
            GAIN_B_BANK0 = trim_r[6];
            GAIN_B_BANK1 = trim_r[7];
        end
        else
        begin
            GAIN_A_BANK0 = trim_r[0];
            GAIN_A_BANK1 = trim_r[1];
            GAIN_B_BANK0 = trim_r[2];
            GAIN_B_BANK1 = trim_r[3];
        end
    end

    // ************************************************************
    // Equalizer slice
    // ************************************************************
    fcgt_cfg_t cfg;
    logic signed [SAMPLE_W-1:0]    prev_a_r;
    logic signed [SAMPLE_W-1:0]    prev_b_r;
    logic signed [SAMPLE_W-1:0]    side_in_a;
    logic signed [SAMPLE_W-1:0]    side_in_b;
    logic signed [FCGT_COEF_W-1:0] coef_bc;
    logic signed [FCGT_COEF_W-1:0] coef_bs;
    logic signed [SAMPLE_W-1:0]    dly_a_r;
    logic signed [SAMPLE_W-1:0]    dly_b_r;
    logic signed [PW-1:0]          pac;
    logic signed [PW-1:0]          pas;
    logic signed [PW-1:0]          pbc;
    logic signed [PW-1:0]          pbs;
    logic signed [PW:0]            out_a_nxt;
    logic signed [PW:0]            out_b_nxt;
    logic signed [PW:0]            out_a_r;
    logic signed [PW:0]            out_b_r;

    assign cfg = fcgt_cfg_t'(cfg_r);

    // Coefficient and side-sample routing
    always_comb
    begin
        coef_bc = cfg.share ? COEF_A_CENTER : COEF_B_CENTER;
        coef_bs = cfg.share ? COEF_A_SIDE   : COEF_B_SIDE;
        if (cfg.merge)
        begin
            side_in_a = prev_b_r;
            side_in_b = SAMPLE_A;
        end
        else
        begin
            side_in_a = prev_a_r;
            side_in_b = prev_b_r;
        end
    end

    fcgt_coef_mac #(.SAMPLE_W(SAMPLE_W)) u_ac (.REF_CLK(REF_CLK), .RST_N(RST_N), .SAMPLE(SAMPLE_A),
        .COEF(COEF_A_CENTER), .SCW(cfg.scw), .CENTER(1'b1), .PRODUCT(pac));
    fcgt_coef_mac #(.SAMPLE_W(SAMPLE_W)) u_as (.REF_CLK(REF_CLK), .RST_N(RST_N), .SAMPLE(side_in_a),
        .COEF(COEF_A_SIDE), .SCW(cfg.scw), .CENTER(1'b0), .PRODUCT(pas));
    fcgt_coef_mac #(.SAMPLE_W(SAMPLE_W)) u_bc (.REF_CLK(REF_CLK), .RST_N(RST_N), .SAMPLE(SAMPLE_B),
        .COEF(coef_bc), .SCW(cfg.scw), .CENTER(1'b1), .PRODUCT(pbc));
    fcgt_coef_mac #(.SAMPLE_W(SAMPLE_W)) u_bs (.REF_CLK(REF_CLK), .RST_N(RST_N), .SAMPLE(side_in_b),
        .COEF(coef_bs), .SCW(cfg.scw), .CENTER(1'b0), .PRODUCT(pbs));

    // Output select: filtered sum or raw sample aligned to product latency
    always_comb
    begin
        if (cfg.mode == FCGT_MODE_ON)
        begin
            out_a_nxt = (PW+1)'(pac) + (PW+1)'(pas);
            out_b_nxt = (PW+1)'(pbc) + (PW+1)'(pbs);
        end
        else
        begin
            out_a_nxt = (PW+1)'(dly_a_r);
            out_b_nxt = (PW+1)'(dly_b_r);
        end
    end

    // Sample history and output registers
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            prev_a_r <= '0;
            prev_b_r <= '0;
            dly_a_r  <= '0;
            dly_b_r  <= '0;
            out_a_r  <= '0;
            out_b_r  <= '0;
        end
        else
        begin
            prev_a_r <= SAMPLE_A;
            prev_b_r <= SAMPLE_B;
            dly_a_r  <= SAMPLE_A;
            dly_b_r  <= SAMPLE_B;
            out_a_r  <= out_a_nxt;
            out_b_r  <= out_b_nxt;
        end
    end

    assign OUT_A = out_a_r;
    assign OUT_B = out_b_r;

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence s_cfg_write;
        REG_WR && REG_ADDR == FCGT_OFS_FILT_CFG && !FUSE_LOAD;
    endsequence

    property p_trim_write;
        @(posedge REF_CLK) disable iff (!RST_N)
        (REG_WR && !FUSE_LOAD && REG_ADDR == FCGT_OFS_FG_B0_TWO) |=> trim_r[2] == $past(REG_WDATA[4:0]);
    endproperty
    a_trim_write: assert property (p_trim_write) else $error("trim write lost");

    property p_trim_read;
        @(posedge REF_CLK) disable iff (!RST_N)
        (REG_RD && !REG_WR && !FUSE_LOAD && REG_ADDR == FCGT_OFS_FG_B1_ONE) |=> REG_RDATA[7:5] == 3'h0
            && REG_RDATA[4:0] == trim_r[7];
    endproperty
    a_trim_read: assert property (p_trim_read) else $error("trim read wrong");

    property p_dual_sel;
        @(posedge REF_CLK) disable iff (!RST_N)
        !SINGLE_CHANNEL |-> GAIN_B_BANK1 == trim_r[3] && GAIN_A_BANK0 == trim_r[0];
    endproperty
    a_dual_sel: assert property (p_dual_sel) else $error("dual trim select wrong");

    property p_single_sel;
        @(posedge REF_CLK) disable iff (!RST_N)
        SINGLE_CHANNEL |-> GAIN_A_BANK1 == trim_r[5] && GAIN_B_BANK0 == trim_r[6];
    endproperty
    a_single_sel: assert property (p_single_sel) else $error("single trim select wrong");

    property p_fuse_load;
        @(posedge REF_CLK) disable iff (!RST_N)
        FUSE_LOAD |=> trim_r[4] == $past(FUSE_TRIM[24:20]);
    endproperty
    a_fuse_load: assert property (p_fuse_load) else $error("fuse default not loaded");

    property p_cfg_write;
        @(posedge REF_CLK) disable iff (!RST_N)
        s_cfg_write |=> cfg_r == $past(REG_WDATA) && FILT_CFG.resv == $past(REG_WDATA[7]);
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("config write lost");

    property p_share;
        @(posedge REF_CLK) disable iff (!RST_N)
        cfg.share |-> coef_bc == COEF_A_CENTER && coef_bs == COEF_A_SIDE;
    endproperty
    a_share: assert property (p_share) else $error("share routing wrong");

    property p_merge;
        @(posedge REF_CLK) disable iff (!RST_N)
        cfg.merge |-> side_in_b == SAMPLE_A && side_in_a == prev_b_r;
    endproperty
    a_merge: assert property (p_merge) else $error("merge routing wrong");

    property p_bypass;
        @(posedge REF_CLK) disable iff (!RST_N)
        (cfg.mode == FCGT_MODE_OFF)[*2] |=> OUT_A == (PW+1)'($past(SAMPLE_A, 2));
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass not transparent");

endmodule : fcgt_top
`default_nettype wire

// >>> verilog/fcgt_pkg.sv
/*
 * Package for the equalizer configuration and fine-gain trim block:
 * register offsets, field positions, reset values and shared types.
 * Assumes an 8-bit register port with a 12-bit byte address.
 */
package fcgt_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [11:0] FCGT_OFS_FG_A0_TWO = 12'h350;
    localparam logic [11:0] FCGT_OFS_FG_A1_TWO = 12'h351;
    localparam logic [11:0] FCGT_OFS_FG_B0_TWO = 12'h352;
    localparam logic [11:0] FCGT_OFS_FG_B1_TWO = 12'h353;
    localparam logic [11:0] FCGT_OFS_FG_A0_ONE = 12'h354;
    localparam logic [11:0] FCGT_OFS_FG_A1_ONE = 12'h355;
    localparam logic [11:0] FCGT_OFS_FG_B0_ONE = 12'h356;
    localparam logic [11:0] FCGT_OFS_FG_B1_ONE = 12'h357;
    localparam logic [11:0] FCGT_OFS_FILT_CFG  = 12'h400;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int          FCGT_GAIN_W        = 5;
    localparam int          FCGT_NUM_TRIMS     = 8;
    localparam int          FCGT_CFG_SHARE_BIT = 6;
    localparam int          FCGT_CFG_MERGE_BIT = 5;
    localparam int          FCGT_CFG_SCW_LSB   = 2;
    localparam int          FCGT_CFG_MODE_LSB  = 0;
    localparam logic [7:0]  FCGT_CFG_RESET     = 8'h00;
    localparam logic [1:0]  FCGT_MODE_OFF      = 2'h0;
    localparam logic [1:0]  FCGT_MODE_ON       = 2'h2;
    localparam logic [4:0]  FCGT_SCW_BIAS      = 5'h10;
    localparam int          FCGT_COEF_W        = 12;

    // Filter control fields as seen by the datapath
    typedef struct packed {
        logic       resv;
        logic       share;
        logic       merge;
        logic [2:0] scw;
        logic [1:0] mode;
    } fcgt_cfg_t;

    // Register port request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } fcgt_req_t;

endpackage : fcgt_pkg

// >>> verilog/fcgt_coef_mac.sv
/*
 * One symmetric-weight coefficient product for the equalizer datapath.
 * Assumes samples and coefficients are signed and on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
module fcgt_coef_mac
    import fcgt_pkg::*;
#(
    parameter int SAMPLE_W = 8
)(
    input  wire logic                          REF_CLK,
    input  wire logic                          RST_N,
    input  wire logic signed [SAMPLE_W-1:0]    SAMPLE,
    input  wire logic signed [FCGT_COEF_W-1:0] COEF,
    input  wire logic [2:0]                    SCW,
    input  wire logic                          CENTER,
    output logic signed [SAMPLE_W+FCGT_COEF_W+6:0] PRODUCT
);

    logic signed [SAMPLE_W+FCGT_COEF_W+6:0] prod_nxt;
    logic signed [SAMPLE_W+FCGT_COEF_W+6:0] prod_r;

    // Side taps are scaled up by the weight field; the center tap is not
    always_comb
    begin
        prod_nxt = (SAMPLE_W+FCGT_COEF_W+7)'(SAMPLE * COEF);
        if (!CENTER)
        begin
            prod_nxt = prod_nxt <<< SCW;
        end
    end

    // Product register
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            prod_r <= '0;
        end
        else
        begin
            prod_r <= prod_nxt;
        end
    end

    assign PRODUCT = prod_r;

endmodule : fcgt_coef_mac
`default_nettype wire

// >>> verification/fir_config_and_gain_trim_tb.sv
/*
 * Self-checking testbench for the equalizer configuration and fine-gain trim block.
 * Assumes fcgt_pkg is compiled first and that the block carries its own assertions.
 */
`timescale 1ns/100ps
`default_nettype none
module fir_config_and_gain_trim_tb
    import fcgt_pkg::*;
;
    // ************************************************************
    // Stimulus and observation signals
    // ************************************************************
    logic                ref_clk;
    logic                rst_n;
    logic                reg_wr;
    logic                reg_rd;
    logic [11:0]         reg_addr;
    logic [7:0]          reg_wdata;
    logic [7:0]          reg_rdata;
    logic                fuse_load;
    logic [39:0]         fuse_trim;
    logic                single_channel;
    logic signed [7:0]   sample_a;
    logic signed [7:0]   sample_b;
    logic signed [11:0]  coef_ac;
    logic signed [11:0]  coef_as;
    logic signed [11:0]  coef_bc;
    logic signed [11:0]  coef_bs;
    logic [4:0]          gain_a0;
    logic [4:0]          gain_a1;
    logic [4:0]          gain_b0;
    logic [4:0]          gain_b1;
    fcgt_cfg_t           filt_cfg;
    logic signed [27:0]  out_a;
    logic signed [27:0]  out_b;
    int                  n_mismatch;
    int                  total_checks;

    fcgt_top #(.SAMPLE_W(8)) dut_u (
        .REF_CLK(ref_clk), .RST_N(rst_n), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
        .FUSE_LOAD(fuse_load), .FUSE_TRIM(fuse_trim), .SINGLE_CHANNEL(single_channel),
        .SAMPLE_A(sample_a), .SAMPLE_B(sample_b), .COEF_A_CENTER(coef_ac),
        .COEF_A_SIDE(coef_as), .COEF_B_CENTER(coef_bc), .COEF_B_SIDE(coef_bs),
        .GAIN_A_BANK0(gain_a0), .GAIN_A_BANK1(gain_a1), .GAIN_B_BANK0(gain_b0),
        .GAIN_B_BANK1(gain_b1), .FILT_CFG(filt_cfg), .OUT_A(out_a), .OUT_B(out_b)
    );

    // Free-running 100 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ************************************************************
    // Shared tasks
    // ************************************************************
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // One-cycle write strobe, launched at the falling edge
    task automatic reg_write(input logic [11:0] addr, input logic [7:0] data);
        @(negedge ref_clk);
        reg_addr  = addr;
        reg_wdata = data;
        reg_wr    = 1'b1;
        @(negedge ref_clk);
        reg_wr    = 1'b0;
    endtask : reg_write

    // One-cycle read strobe; data is registered at the edge that takes it
    task automatic reg_read(input logic [11:0] addr, output logic [7:0] data);
        @(negedge ref_clk);
        reg_addr = addr;
        reg_rd   = 1'b1;
        @(negedge ref_clk);
        reg_rd   = 1'b0;
        data     = reg_rdata;
    endtask : reg_read

    // Reset held for 20 cycles
    task automatic do_reset;
        @(negedge ref_clk);
        rst_n          = 1'b0;
        single_channel = 1'b0;
        repeat (20) @(negedge ref_clk);
        rst_n = 1'b1;
    endtask : do_reset

    // ************************************************************
    // Scenarios
    // ************************************************************
    // All nine registers and the applied values read zero after reset
    task automatic test_reset_values;
        logic [7:0] d;
        for (int i = 0; i < 9; i++)
        begin
            reg_read((i < 8) ? FCGT_OFS_FG_A0_TWO + 12'(i) : FCGT_OFS_FILT_CFG, d);
            check(32'(d), 32'h0);
        end
        check(32'({gain_a0, gain_a1, gain_b0, gain_b1}), 32'h0);
        check(32'(filt_cfg), 32'h0);
        $display("test reset_values done");
    endtask : test_reset_values

    // Trim write, reserved bits dropped, dual and single sets applied apart
    task automatic test_trims;
        logic [7:0] d;
        for (int i = 0; i < 8; i++)
            reg_write(FCGT_OFS_FG_A0_TWO + 12'(i), 8'hE0 | 8'(i * 4 + 3));
        reg_write(12'h358, 8'hFF);
        for (int i = 0; i < 8; i++)
        begin
            reg_read(FCGT_OFS_FG_A0_TWO + 12'(i), d);
            check(32'(d), 32'(i * 4 + 3));
        end
        reg_read(12'h358, d);
        check(32'(d), 32'h0);
        single_channel = 1'b0;
        @(negedge ref_clk);
        check(32'({gain_a0, gain_a1, gain_b0, gain_b1}), {12'h0, 5'd3, 5'd7, 5'd11, 5'd15});
        single_channel = 1'b1;
        @(negedge ref_clk);
        check(32'({gain_a0, gain_a1, gain_b0, gain_b1}), {12'h0, 5'd19, 5'd23, 5'd27, 5'd31});
        single_channel = 1'b0;
        $display("test trims done");
    endtask : test_trims

    // Fuse load wins over a write in the same cycle
    task automatic test_fuse;
        logic [7:0] d;
        for (int i = 0; i < 8; i++)
            fuse_trim[5 * i +: 5] = 5'(5'h10 + i * 2);
        @(negedge ref_clk);
        fuse_load = 1'b1;
        reg_addr  = FCGT_OFS_FG_A0_TWO;
        reg_wdata = 8'h0A;
        reg_wr    = 1'b1;
        @(negedge ref_clk);
        fuse_load = 1'b0;
        reg_wr    = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            reg_read(FCGT_OFS_FG_A0_TWO + 12'(i), d);
            check(32'(d), 32'(5'h10 + i * 2));
        end
        $display("test fuse done");
    endtask : test_fuse

    // Every config bit writable, reserved bit 7 included
    task automatic test_cfg;
        logic [7:0] d;
        reg_write(FCGT_OFS_FILT_CFG, 8'hFB);
        reg_read(FCGT_OFS_FILT_CFG, d);
        check(32'(d), 32'hFB);
        check(32'(filt_cfg), 32'hFB);
        check(32'(filt_cfg.scw), 32'h6);
        reg_write(FCGT_OFS_FILT_CFG, 8'h84);
        reg_read(FCGT_OFS_FILT_CFG, d);
        check(32'(d), 32'h84);
        $display("test cfg done");
    endtask : test_cfg

    // Modes 0, 1 and 3 pass the sample through in two cycles, mode 2 filters
    task automatic test_modes;
        int ea;
        sample_a = -8'sd7;
        sample_b = 8'sd6;
        for (int m = 0; m < 4; m++)
        begin
            reg_write(FCGT_OFS_FILT_CFG, 8'(m));
            repeat (4) @(negedge ref_clk);
            ea = (m == 2) ? -7 * 4 + -7 * -2 : -7;
            check(32'(out_a), 32'(ea));
            check(32'(out_b), 32'((m == 2) ? 6 * 7 + 6 * 1 : 6));
        end
        reg_write(FCGT_OFS_FILT_CFG, 8'h00);
        repeat (3) @(negedge ref_clk);
        sample_a = 8'sh12;
        @(negedge ref_clk);
        check(32'(out_a), 32'(-7));
        @(negedge ref_clk);
        check(32'(out_a), 32'h12);
        $display("test modes done");
    endtask : test_modes

    // Side weight, sharing and merging against a worked product
    task automatic test_filter;
        logic [7:0] cfg;
        int         sh;
        int         ea;
        int         eb;
        sample_a = 8'sd3;
        sample_b = 8'sd5;
        for (int k = 0; k < 10; k++)
        begin
            cfg = (k < 7) ? 8'(k * 4 + 2) : 8'(8'h0A | (8'(k - 6) << 5));
            single_channel = cfg[FCGT_CFG_MERGE_BIT];
            sh = cfg[4:2];
            reg_write(FCGT_OFS_FILT_CFG, cfg);
            repeat (4) @(negedge ref_clk);
            ea = 3 * 4 + (((cfg[5] ? 5 : 3) * -2) <<< sh);
            eb = cfg[6] ? 5 * 4 + (((cfg[5] ? 3 : 5) * -2) <<< sh)
                        : 5 * 7 + (((cfg[5] ? 3 : 5) * 1) <<< sh);
            check(32'(out_a), 32'(ea));
            check(32'(out_b), 32'(eb));
        end
        // Merged and shared: a new B sample reaches B's center first, A's side tap a cycle later
        sample_b = 8'sd9;
        repeat (2) @(negedge ref_clk);
        check(32'(out_a), 32'(3 * 4 + ((5 * -2) <<< 2)));
        check(32'(out_b), 32'(9 * 4 + ((3 * -2) <<< 2)));
        @(negedge ref_clk);
        check(32'(out_a), 32'(3 * 4 + ((9 * -2) <<< 2)));
        $display("test filter done");
    endtask : test_filter

    // ************************************************************
    // Closing and main sequence
    // ************************************************************
    task automatic summarize;
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    // Watchdog well beyond the few hundred cycles the tests take
    initial
    begin
        #200000;
        n_mismatch++;
        summarize();
    end

    // Main sequence
    initial
    begin
        n_mismatch     = 0;
        total_checks   = 0;
        rst_n          = 1'b0;
        reg_wr         = 1'b0;
        reg_rd         = 1'b0;
        reg_addr       = 12'h000;
        reg_wdata      = 8'h00;
        fuse_load      = 1'b0;
        fuse_trim      = 40'h0;
        single_channel = 1'b0;
        sample_a       = 8'sh00;
        sample_b       = 8'sh00;
        coef_ac        = 12'sd4;
        coef_as        = -12'sd2;
        coef_bc        = 12'sd7;
        coef_bs        = 12'sd1;
        do_reset();
        test_reset_values();
        test_trims();
        test_fuse();
        test_cfg();
        test_modes();
        test_filter();
        do_reset();
        test_reset_values();
        summarize();
    end
endmodule : fir_config_and_gain_trim_tb
`default_nettype wire
